// *** rtl/cry_map.vh ***
// field offsets, codes and counts for the symmetric/aead request parser
`ifndef CRY_MAP_VH
`define CRY_MAP_VH
// general header, in 32-bit words
`define CRY_HDR_WORDS 3'h6
`define CRY_HDR_OPCODE 3'h0
`define CRY_HDR_SID_LO 3'h2
`define CRY_HDR_SID_HI 3'h3
`define CRY_HDR_FLAG 3'h4
`define CRY_FLAG_SESSION 32'h00000001
// opcodes
`define CRY_OPC_CIPHER_ENC 32'h00000000
`define CRY_OPC_CIPHER_DEC 32'h00000001
`define CRY_OPC_AEAD_ENC 32'h00000300
`define CRY_OPC_AEAD_DEC 32'h00000301
// symmetric op types
`define CRY_SYM_CIPHER 32'h00000001
`define CRY_SYM_CHAIN 32'h00000002
// body length in words: symmetric 40/72-byte header plus op_type (plus padding), aead 24/32-byte header
`define CRY_SYM_SS_WORDS 5'h0C
`define CRY_SYM_SL_WORDS 5'h13
`define CRY_SYM_SS_OPT 5'h0A
`define CRY_SYM_SL_OPT 5'h12
`define CRY_AEAD_SS_WORDS 5'h06
`define CRY_AEAD_SL_WORDS 5'h08
// cipher fields
`define CRY_CI_SS_IV 5'h00
`define CRY_CI_SL_IV 5'h03
// chain fields (iv, src, dst follow in order; aad and hash further on)
`define CRY_CH_SS_IV 5'h00
`define CRY_CH_SS_AAD 5'h07
`define CRY_CH_SS_HASH 5'h08
`define CRY_CH_SL_IV 5'h08
`define CRY_CH_SL_AAD 5'h0F
`define CRY_CH_SL_HASH 5'h10
// aead fields
`define CRY_AE_SS_IV 5'h00
`define CRY_AE_SS_AAD 5'h01
`define CRY_AE_SS_SRC 5'h02
`define CRY_AE_SS_DST 5'h03
`define CRY_AE_SS_TAG 5'h04
`define CRY_AE_SL_IV 5'h03
`define CRY_AE_SL_TAG 5'h04
`define CRY_AE_SL_AAD 5'h05
`define CRY_AE_SL_SRC 5'h06
`define CRY_AE_SL_DST 5'h07
// completion codes
`define CRY_ST_OK 8'h00
`define CRY_ST_ERR 8'h01
`define CRY_ST_BADMSG 8'h02
`define CRY_ST_NOTSUPP 8'h03
`define CRY_ST_INVSESS 8'h04
`endif

// *** rtl/cry_buf2.v ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module cry_buf2 #(
    parameter W = 34
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire empty
);
    reg [W-1:0] mem_r [0:1];
    reg wp_r;
    reg rp_r;
    reg [1:0] cnt_r;
    wire push;
    wire pop;

    // handshakes from occupancy
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign empty = (cnt_r == 2'h0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage and pointers
    always @(posedge clk) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_data;
                wp_r <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule // cry_buf2

// *** rtl/cry_req_parser.v ***
// request decoder and completion for cipher, chaining and aead requests
`timescale 1ns/1ps
`include "cry_map.vh"
module cry_req_parser (
    // clock and reset
    input wire clk,
    input wire rst,
    // negotiated features
    input wire feat_cipher_sl,
    input wire feat_aead_sl,
    // request words from the data queue
    input wire req_valid,
    input wire [31:0] req_data,
    input wire req_last,
    output wire req_ready,
    // session lookup
    output wire [63:0] sess_id,
    input wire sess_ok,
    // command to the cipher engine
    output wire cmd_valid,
    input wire cmd_ready,
    output reg cmd_aead,
    output reg cmd_chain,
    output reg cmd_decrypt,
    output reg cmd_stateless,
    output reg cmd_aad_rd,
    output reg [31:0] cmd_iv_len,
    output reg [31:0] cmd_src_len,
    output reg [31:0] cmd_dst_len,
    output reg [31:0] cmd_aad_len,
    output reg [31:0] cmd_aux_len,
    // engine results: kind 0 cipher output, 1 hash or tag
    input wire res_valid,
    output wire res_ready,
    input wire [31:0] res_data,
    input wire res_kind,
    input wire iv_upd_valid,
    input wire [1:0] iv_upd_idx,
    input wire [31:0] iv_upd_data,
    input wire done_valid,
    input wire done_unsupp,
    input wire done_err,
    input wire done_tag_ok,
    // writes into the request's write-only part
    output wire wr_valid,
    input wire wr_ready,
    output wire [31:0] wr_addr,
    output wire [31:0] wr_data,
    output reg iv_wr_valid,
    output reg [1:0] iv_wr_idx,
    output reg [31:0] iv_wr_data,
    // completion status
    output wire sts_valid,
    input wire sts_ready,
    output reg [7:0] sts_code
);
    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    localparam S_HDR = 3'h0;
    localparam S_BODY = 3'h1;
    localparam S_DRAIN = 3'h2;
    localparam S_DEC = 3'h3;
    localparam S_CMD = 3'h4;
    localparam S_RUN = 3'h5;
    localparam S_FLUSH = 3'h6;
    localparam S_STS = 3'h7;
    reg [2:0] st_r;
    reg [4:0] wcnt_r;
    reg [31:0] opc_r;
    reg [31:0] flag_r;
    reg [63:0] sid_r;
    reg [31:0] optype_r;
    reg [31:0] flf_r [0:17];
    reg bad_r;
    reg [31:0] dcnt_r;
    reg [31:0] acnt_r;
    reg [31:0] abase_r;
    wire take;
    wire is_aead;
    wire is_sym;
    wire sl_mode;
    wire [4:0] body_n;
    wire [4:0] opt_idx;
    wire res_take;
    wire buf_in_ready;
    wire buf_empty;
    wire [63:0] buf_out;
    wire [31:0] addr_nxt;
    // field fetch by word index
    function [31:0] fld(input [4:0] idx);
        fld = flf_r[idx];
    endfunction
    // ------------------------------------------------------------
    // header decode
    // ------------------------------------------------------------
    // opcode picks service
    assign is_aead = (opc_r == `CRY_OPC_AEAD_ENC) || (opc_r == `CRY_OPC_AEAD_DEC);
    assign is_sym = (opc_r == `CRY_OPC_CIPHER_ENC) || (opc_r == `CRY_OPC_CIPHER_DEC);
    assign sl_mode = (is_aead ? feat_aead_sl : feat_cipher_sl) && (flag_r == 32'h00000000);
    assign body_n = is_aead ? (sl_mode ? `CRY_AEAD_SL_WORDS : `CRY_AEAD_SS_WORDS)
                            : (sl_mode ? `CRY_SYM_SL_WORDS : `CRY_SYM_SS_WORDS);
    assign opt_idx = sl_mode ? `CRY_SYM_SL_OPT : `CRY_SYM_SS_OPT;
    assign sess_id = sid_r;
    // queue and engine handshakes
    assign req_ready = (st_r == S_HDR) || (st_r == S_BODY) || (st_r == S_DRAIN);
    assign take = req_valid && req_ready;
    assign cmd_valid = (st_r == S_CMD);
    assign res_ready = (st_r == S_RUN) && buf_in_ready;
    assign res_take = res_valid && res_ready;
    assign sts_valid = (st_r == S_STS);
    assign addr_nxt = res_kind ? abase_r + acnt_r : dcnt_r;
    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            st_r <= S_HDR;
            wcnt_r <= 5'h00;
            opc_r <= 32'h00000000;
            flag_r <= 32'h00000000;
            sid_r <= 64'h0000000000000000;
            optype_r <= 32'h00000000;
            bad_r <= 1'b0;
            sts_code <= `CRY_ST_OK;
            cmd_aead <= 1'b0;
            cmd_chain <= 1'b0;
            cmd_decrypt <= 1'b0;
            cmd_stateless <= 1'b0;
            cmd_aad_rd <= 1'b0;
            cmd_iv_len <= 32'h00000000;
            cmd_src_len <= 32'h00000000;
            cmd_dst_len <= 32'h00000000;
            cmd_aad_len <= 32'h00000000;
            cmd_aux_len <= 32'h00000000;
            dcnt_r <= 32'h00000000;
            acnt_r <= 32'h00000000;
            abase_r <= 32'h00000000;
        end else begin
            case (st_r)
                S_HDR: begin
                    if (take) begin
                        case (wcnt_r[2:0])
                            `CRY_HDR_OPCODE: opc_r <= req_data;
                            `CRY_HDR_SID_LO: sid_r[31:0] <= req_data;
                            `CRY_HDR_SID_HI: sid_r[63:32] <= req_data;
                            `CRY_HDR_FLAG: flag_r <= req_data;
                            default: ;
                        endcase
                        if (req_last) begin
                            bad_r <= 1'b1;
                            st_r <= S_DEC;
                        end else if (wcnt_r[2:0] == `CRY_HDR_WORDS - 3'h1) begin
                            wcnt_r <= 5'h00;
                            st_r <= S_BODY;
                        end else begin
                            wcnt_r <= wcnt_r + 5'h01;
                        end
                    end
                end
                S_BODY: begin
                    if (take) begin
                        if (wcnt_r < 5'h12)
                            flf_r[wcnt_r] <= req_data;
                        if (is_sym && wcnt_r == opt_idx)
                            optype_r <= req_data;
                        wcnt_r <= wcnt_r + 5'h01;
                        if (wcnt_r == body_n - 5'h01)
                            st_r <= req_last ? S_DEC : S_DRAIN;
                        else if (req_last) begin
                            bad_r <= 1'b1;
                            st_r <= S_DEC;
                        end
                    end
                end
                // variable part is fetched by the engine itself
                S_DRAIN: begin
                    if (take && req_last)
                        st_r <= S_DEC;
                end
                S_DEC: begin
                    wcnt_r <= 5'h00;
                    dcnt_r <= 32'h00000000;
                    acnt_r <= 32'h00000000;
                    bad_r <= 1'b0;
                    cmd_aead <= is_aead;
                    cmd_stateless <= sl_mode;
                    cmd_decrypt <= opc_r[0];
                    cmd_chain <= is_sym && (optype_r == `CRY_SYM_CHAIN);
                    if (!is_aead && !is_sym) begin
                        sts_code <= `CRY_ST_NOTSUPP;
                        st_r <= S_STS;
                    end else if (bad_r) begin
                        sts_code <= `CRY_ST_ERR;
                        st_r <= S_STS;
                    end else if (!sl_mode && !sess_ok) begin
                        sts_code <= `CRY_ST_INVSESS;
                        st_r <= S_STS;
                    end else if (is_sym && optype_r != `CRY_SYM_CIPHER
                                 && optype_r != `CRY_SYM_CHAIN) begin
                        sts_code <= `CRY_ST_NOTSUPP;
                        st_r <= S_STS;
                    end else if (is_aead) begin
                        cmd_iv_len <= fld(sl_mode ? `CRY_AE_SL_IV : `CRY_AE_SS_IV);
                        cmd_aad_len <= fld(sl_mode ? `CRY_AE_SL_AAD : `CRY_AE_SS_AAD);
                        cmd_src_len <= fld(sl_mode ? `CRY_AE_SL_SRC : `CRY_AE_SS_SRC);
                        cmd_dst_len <= fld(sl_mode ? `CRY_AE_SL_DST : `CRY_AE_SS_DST);
                        cmd_aux_len <= fld(sl_mode ? `CRY_AE_SL_TAG : `CRY_AE_SS_TAG);
                        cmd_aad_rd <= |fld(sl_mode ? `CRY_AE_SL_AAD : `CRY_AE_SS_AAD);
                        abase_r <= fld(sl_mode ? `CRY_AE_SL_SRC : `CRY_AE_SS_SRC);
                        st_r <= S_CMD;
                    end else if (optype_r == `CRY_SYM_CIPHER) begin
                        cmd_iv_len <= fld(sl_mode ? `CRY_CI_SL_IV : `CRY_CI_SS_IV);
                        cmd_src_len <= fld((sl_mode ? `CRY_CI_SL_IV : `CRY_CI_SS_IV) + 5'h01);
                        cmd_dst_len <= fld((sl_mode ? `CRY_CI_SL_IV : `CRY_CI_SS_IV) + 5'h02);
                        cmd_aad_len <= 32'h00000000;
                        cmd_aux_len <= 32'h00000000;
                        cmd_aad_rd <= 1'b0;
                        abase_r <= 32'h00000000;
                        st_r <= S_CMD;
                    end else begin
                        cmd_iv_len <= fld(sl_mode ? `CRY_CH_SL_IV : `CRY_CH_SS_IV);
                        cmd_src_len <= fld((sl_mode ? `CRY_CH_SL_IV : `CRY_CH_SS_IV) + 5'h01);
                        cmd_dst_len <= fld((sl_mode ? `CRY_CH_SL_IV : `CRY_CH_SS_IV) + 5'h02);
                        cmd_aad_len <= fld(sl_mode ? `CRY_CH_SL_AAD : `CRY_CH_SS_AAD);
                        cmd_aux_len <= fld(sl_mode ? `CRY_CH_SL_HASH : `CRY_CH_SS_HASH);
                        cmd_aad_rd <= |fld(sl_mode ? `CRY_CH_SL_AAD : `CRY_CH_SS_AAD);
                        abase_r <= fld((sl_mode ? `CRY_CH_SL_IV : `CRY_CH_SS_IV) + 5'h02);
                        st_r <= S_CMD;
                    end
                end
                S_CMD: begin
                    if (cmd_ready)
                        st_r <= S_RUN;
                end
                S_RUN: begin
                    if (res_take && !res_kind)
                        dcnt_r <= dcnt_r + 32'h00000004;
                    if (res_take && res_kind)
                        acnt_r <= acnt_r + 32'h00000004;
                    if (done_valid) begin
                        st_r <= S_FLUSH;
                        if (done_unsupp)
                            sts_code <= `CRY_ST_NOTSUPP;
                        else if (cmd_aead && cmd_decrypt && !done_tag_ok)
                            sts_code <= `CRY_ST_BADMSG;
                        else if (done_err)
                            sts_code <= `CRY_ST_ERR;
                        else
                            sts_code <= `CRY_ST_OK;
                    end
                end
                S_FLUSH: begin
                    if (buf_empty)
                        st_r <= S_STS;
                end
                S_STS: begin
                    if (sts_ready)
                        st_r <= S_HDR;
                end
                default: st_r <= S_HDR;
            endcase
        end
    end
    // ------------------------------------------------------------
    // iv write-back and output buffer
    // ------------------------------------------------------------
    // iv updated per partial op
    always @(posedge clk) begin
        if (rst) begin
            iv_wr_valid <= 1'b0;
            iv_wr_idx <= 2'h0;
            iv_wr_data <= 32'h00000000;
        end else begin
            iv_wr_valid <= iv_upd_valid && (st_r == S_RUN);
            if (iv_upd_valid) begin
                iv_wr_idx <= iv_upd_idx;
                iv_wr_data <= iv_upd_data;
            end
        end
    end
    // stall from the writer reaches the engine
    cry_buf2 #(.W(64)) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(res_valid && (st_r == S_RUN)),
        .in_ready(buf_in_ready),
        .in_data({addr_nxt, res_data}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(buf_out),
        .empty(buf_empty)
    );
    assign wr_addr = buf_out[63:32];
    assign wr_data = buf_out[31:0];
endmodule // cry_req_parser

// *** bench/cry_drv_model.sv ***
// guest-side poster of request words for the request parser bench
`timescale 1ns/1ps
module cry_drv_model (
    // clock
    input wire clk,
    // pacing: one idle cycle after each word
    input wire slow,
    // request words
    output wire req_valid,
    input wire req_ready,
    output wire [31:0] req_data,
    output wire req_last
);
    logic [31:0] mem [0:31];
    logic [31:0] last_r = 32'h0;
    logic gap_r = 1'b0;
    int n = 0;
    int idx = 0;

    assign req_valid = (idx < n) && !gap_r;
    assign req_last = req_valid && (idx == n - 1);
    // released bus shows the inverse of the last word
    assign req_data = req_valid ? mem[idx] : ~last_r;

    // advance only on an accepted word
    always @(posedge clk) begin
        gap_r <= 1'b0;
        if (req_valid && req_ready) begin
            last_r <= req_data;
            idx <= idx + 1;
            gap_r <= slow;
        end
    end

    task post(input int len);
        idx = 0;
        n = len;
    endtask
endmodule // cry_drv_model

// *** bench/cry_req_assertions.sv ***
// concurrent checks on the request parser ports
`timescale 1ns/1ps
module cry_req_checker (
    // clock and reset
    input wire clk,
    input wire rst,
    // features and request side
    input wire feat_cipher_sl,
    input wire feat_aead_sl,
    input wire req_ready,
    // command side
    input wire cmd_valid,
    input wire cmd_aead,
    input wire cmd_decrypt,
    input wire cmd_stateless,
    input wire cmd_aad_rd,
    input wire [31:0] cmd_aad_len,
    // iv and completion from engine
    input wire iv_upd_valid,
    input wire [31:0] iv_upd_data,
    input wire iv_wr_valid,
    input wire [31:0] iv_wr_data,
    input wire done_valid,
    input wire done_unsupp,
    input wire done_err,
    input wire done_tag_ok,
    // writes and status
    input wire wr_valid,
    input wire wr_ready,
    input wire [31:0] wr_addr,
    input wire [31:0] wr_data,
    input wire sts_valid,
    input wire sts_ready,
    input wire [7:0] sts_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_MODE_CIPHER: assert property (cmd_valid && !cmd_aead && !feat_cipher_sl |-> !cmd_stateless)
        else $error("cipher stateless without feature");
    AST_MODE_AEAD: assert property (cmd_valid && cmd_aead && !feat_aead_sl |-> !cmd_stateless)
        else $error("aead stateless without feature");
    AST_REQ_HELD: assert property (cmd_valid |-> !req_ready)
        else $error("request taken during command");
    AST_AAD_GATE: assert property (cmd_valid |-> cmd_aad_rd == (cmd_aad_len != 32'h0))
        else $error("aad read flag wrong");
    AST_IV_BACK: assert property (iv_wr_valid |-> $past(iv_upd_valid) && iv_wr_data == $past(iv_upd_data))
        else $error("iv write-back wrong");
    AST_WR_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
        else $error("write dropped before ready");
    AST_STS_LAST: assert property (sts_valid |-> !wr_valid)
        else $error("status ahead of data");
    AST_STS_HOLD: assert property (sts_valid && !sts_ready |=> sts_valid && $stable(sts_code))
        else $error("status dropped before ready");
    AST_ST_UNSUPP: assert property (done_valid && done_unsupp |-> ##[1:40] sts_valid && sts_code == 8'h03)
        else $error("unsupported code missing");
    AST_ST_BAD: assert property (done_valid && !done_unsupp && cmd_aead && cmd_decrypt
        && !done_tag_ok |-> ##[1:40] sts_valid && sts_code == 8'h02)
        else $error("bad message code missing");
    AST_ST_ERR: assert property (done_valid && !done_unsupp && done_err && done_tag_ok
        |-> ##[1:40] sts_valid && sts_code == 8'h01)
        else $error("error code missing");
    AST_ST_OK: assert property (done_valid && !done_unsupp && !done_err && done_tag_ok
        |-> ##[1:40] sts_valid && sts_code == 8'h00)
        else $error("success code missing");
endmodule // cry_req_checker

bind cry_req_parser cry_req_checker i_cry_req_checker (.*);

// *** bench/tb.sv ***
// self-checking testbench for the request parser
`timescale 1ns/1ps
`include "cry_map.vh"
module tb;
    logic clk, rst, feat_cipher_sl, feat_aead_sl, sess_ok, cmd_ready, slow;
    logic res_valid, res_kind, iv_upd_valid, done_valid, done_unsupp, done_err, done_tag_ok;
    logic wr_ready, sts_ready;
    logic [31:0] res_data, iv_upd_data;
    logic [1:0] iv_upd_idx;
    wire req_valid, req_last, req_ready, cmd_valid, res_ready, wr_valid, sts_valid, iv_wr_valid;
    wire cmd_aead, cmd_chain, cmd_decrypt, cmd_stateless, cmd_aad_rd;
    wire [31:0] req_data, wr_addr, wr_data, iv_wr_data;
    wire [31:0] cmd_iv_len, cmd_src_len, cmd_dst_len, cmd_aad_len, cmd_aux_len;
    wire [63:0] sess_id;
    wire [1:0] iv_wr_idx;
    wire [7:0] sts_code;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] ea[$], ed[$];

    cry_req_parser i_cry_req_parser (.*);
    cry_drv_model i_cry_drv_model (.*);

    // ---------------------------------
    // clock, drain stall and watchdog
    // ---------------------------------
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // drain side ready one cycle in four
    always @(negedge clk) begin
        cyc <= cyc + 1;
        wr_ready <= (cyc % 4 == 3);
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    // every stored word checked against queue
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready) begin
            if (ea.size() == 0) begin
                cmp(wr_addr, 32'hFFFFFFFF);
            end else begin
                cmp(wr_addr, ea.pop_front());
                cmp(wr_data, ed.pop_front());
            end
        end
    end

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task end_of_test;
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task hdr(input logic [31:0] opc, input logic [31:0] flag);
        for (int i = 0; i < 32; i++)
            i_cry_drv_model.mem[i] = 32'h0;
        i_cry_drv_model.mem[0] = opc;
        i_cry_drv_model.mem[2] = 32'h1234ABCD;
        i_cry_drv_model.mem[3] = 32'h00C0FFEE;
        i_cry_drv_model.mem[4] = flag;
    endtask

    task bw(input int k, input logic [31:0] v);
        i_cry_drv_model.mem[6 + k] = v;
    endtask

    task post_req(input int n);
        i_cry_drv_model.post(n);
        for (int i = 0; i < 200 && cmd_valid !== 1'b1 && sts_valid !== 1'b1; i++)
            @(negedge clk);
    endtask

    task get_sts(input logic [7:0] exp);
        for (int i = 0; i < 100 && sts_valid !== 1'b1; i++)
            @(negedge clk);
        cmp({24'h0, sts_code}, {24'h0, exp});
        cmp(ea.size(), 0);
        sts_ready = 1;
        @(negedge clk);
        sts_ready = 0;
    endtask

    task chk_cmd(input logic [4:0] f, input logic [31:0] iv, input logic [31:0] src,
                 input logic [31:0] dst);
        cmp(cmd_valid, 1);
        cmp({cmd_aead, cmd_chain, cmd_decrypt, cmd_stateless, cmd_aad_rd}, f);
        cmp(cmd_iv_len, iv);
        cmp(cmd_src_len, src);
        cmp(cmd_dst_len, dst);
    endtask

    task run_eng(input int n0, input int n1, input logic [31:0] base, input logic [2:0] dn,
                 input logic [7:0] exp);
        cmd_ready = 1;
        @(negedge clk);
        cmd_ready = 0;
        iv_upd_valid = 1;
        iv_upd_idx = 2'h2;
        iv_upd_data = 32'h1F2E3D4C;
        @(negedge clk);
        iv_upd_valid = 0;
        cmp(iv_wr_valid, 1);
        cmp(iv_wr_idx, 2);
        cmp(iv_wr_data, 32'h1F2E3D4C);
        for (int i = 0; i < n0 + n1; i++) begin
            res_valid = 1;
            res_kind = (i >= n0);
            res_data = 32'hD0000000 + i;
            ed.push_back(res_data);
            ea.push_back(i < n0 ? 4 * i : base + 4 * (i - n0));
            // hold the word until an edge that sees res_ready high
            for (int k = 0; k < 50 && res_ready !== 1'b1; k++)
                @(negedge clk);
            @(negedge clk);
        end
        res_valid = 0;
        {done_unsupp, done_err, done_tag_ok} = dn;
        done_valid = 1;
        @(negedge clk);
        done_valid = 0;
        get_sts(exp);
    endtask

    task err_case(input logic [31:0] opc, input logic [31:0] flag, input logic fcs,
                  input logic sok, input logic [31:0] opt, input int nb, input logic [7:0] exp);
        feat_cipher_sl = fcs;
        sess_ok = sok;
        hdr(opc, flag);
        bw(10, opt);
        post_req(6 + nb);
        cmp(cmd_valid, 0);
        get_sts(exp);
        sess_ok = 1;
    endtask

    task s_cipher;
        hdr(`CRY_OPC_CIPHER_ENC, `CRY_FLAG_SESSION);
        bw(0, 16);
        bw(1, 8);
        bw(2, 8);
        bw(10, `CRY_SYM_CIPHER);
        bw(12, 32'hDEAD0000);
        post_req(19);
        chk_cmd(5'b00000, 16, 8, 8);
        cmp(sess_id[31:0], 32'h1234ABCD);
        cmp(sess_id[63:32], 32'h00C0FFEE);
        run_eng(2, 0, 0, 3'b001, 8'h00);
    endtask

    task s_chain;
        feat_cipher_sl = 1;
        slow = 1;
        hdr(`CRY_OPC_CIPHER_DEC, 0);
        bw(8, 16);
        bw(9, 8);
        bw(10, 8);
        bw(16, 4);
        bw(18, `CRY_SYM_CHAIN);
        post_req(25);
        slow = 0;
        chk_cmd(5'b01110, 16, 8, 8);
        cmp(cmd_aux_len, 4);
        run_eng(2, 1, 8, 3'b011, 8'h01);
    endtask

    task s_aead_dec;
        feat_cipher_sl = 0;
        hdr(`CRY_OPC_AEAD_DEC, `CRY_FLAG_SESSION);
        bw(0, 12);
        bw(1, 8);
        bw(2, 8);
        bw(3, 12);
        bw(4, 4);
        post_req(12);
        chk_cmd(5'b10101, 12, 8, 12);
        cmp(cmd_aad_len, 8);
        cmp(cmd_aux_len, 4);
        run_eng(2, 1, 8, 3'b000, 8'h02);
    endtask

    task s_aead_sl;
        feat_aead_sl = 1;
        hdr(`CRY_OPC_AEAD_ENC, 0);
        bw(3, 13);
        bw(4, 8);
        bw(6, 4);
        bw(7, 12);
        post_req(14);
        chk_cmd(5'b10010, 13, 4, 12);
        cmp(cmd_aux_len, 8);
        run_eng(1, 2, 4, 3'b101, 8'h03);
        feat_aead_sl = 0;
    endtask

    task s_modes;
        feat_cipher_sl = 1;
        hdr(`CRY_OPC_CIPHER_ENC, 0);
        bw(3, 16);
        bw(4, 4);
        bw(5, 4);
        bw(18, `CRY_SYM_CIPHER);
        post_req(25);
        chk_cmd(5'b00010, 16, 4, 4);
        run_eng(1, 0, 0, 3'b001, 8'h00);
        hdr(`CRY_OPC_CIPHER_ENC, `CRY_FLAG_SESSION);
        bw(0, 16);
        bw(1, 8);
        bw(2, 8);
        bw(7, 4);
        bw(8, 4);
        bw(10, `CRY_SYM_CHAIN);
        post_req(18);
        chk_cmd(5'b01001, 16, 8, 8);
        cmp(cmd_aad_len, 4);
        cmp(cmd_aux_len, 4);
        run_eng(2, 1, 8, 3'b001, 8'h00);
    endtask

    task s_errors;
        err_case(32'h00000002, 1, 1, 1, 1, 12, 8'h03);
        err_case(`CRY_OPC_CIPHER_ENC, 1, 1, 0, 1, 12, 8'h04);
        err_case(`CRY_OPC_CIPHER_ENC, 0, 0, 0, 1, 12, 8'h04);
        err_case(`CRY_OPC_CIPHER_ENC, 1, 1, 1, 3, 12, 8'h03);
        err_case(`CRY_OPC_CIPHER_ENC, 1, 1, 1, 1, 4, 8'h01);
    endtask

    // main sequence
    initial begin
        {rst, sess_ok} = 2'b11;
        {feat_cipher_sl, feat_aead_sl, cmd_ready, slow, res_valid, res_kind} = 6'h0;
        {iv_upd_valid, done_valid, done_unsupp, done_err, done_tag_ok} = 5'h0;
        {wr_ready, sts_ready, iv_upd_idx} = 4'h0;
        res_data = 32'h0;
        iv_upd_data = 32'h0;
        repeat (2) @(negedge clk);
        rst = 0;
        s_cipher();
        s_chain();
        s_aead_dec();
        s_aead_sl();
        s_errors();
        s_modes();
        end_of_test();
    end
endmodule // tb
